// ==== rtl/sdb_ctl.sv ====
// Purpose: register-driven command issuer for the burst memory device
// Assumes: software spaces orders by polling the busy bit
// Notes:   read data of the last word seen is held in REG_RDATA
`timescale 1ns/10ps
module sdb_ctl #(
  parameter int ADDR_W    = 13,
  parameter int DATA_W    = 16,
  parameter int PD_LIMIT  = sdb_pkg::REF_CYC  // longest power-down stay
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // memory pins
  sdb_if.ctl               pins
);
  import sdb_pkg::*;

  initial begin
    if (DATA_W > 16 || ADDR_W != 13 || PD_LIMIT < 2)
      $error("sdb_ctl: unsupported parameters");
  end

  typedef enum logic [1:0] {SDB_IDLE, SDB_WAIT, SDB_MASK, SDB_SLEEP} sdb_st_t;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  sdb_st_t           st_reg;
  logic [1:0]        wait_reg;
  logic [31:0]       pd_cnt_reg;
  logic [3:0]        cmd_reg;
  logic [1:0]        bank_reg;
  logic [12:0]       addr_reg;
  logic [DATA_W-1:0] wd_reg;
  logic              wd_oe_n_reg;
  logic              dqm_reg;
  logic              cke_reg;
  logic              wr_mode_reg;
  logic [2:0]        rd_track_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic              rvalid_reg;
  logic [31:0]       pend_reg;
  sdb_op_t           op;
  logic              cmd_wr;
  logic              data_wr;

  assign op      = sdb_op_t'(reg_wdata[3:0]);
  assign cmd_wr  = reg_wr && reg_addr == REG_CMD && st_reg == SDB_IDLE;
  assign data_wr = reg_wr && reg_addr == REG_WDATA;

  // order sequencer: delays, read masking and power-down watchdog
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_reg     <= SDB_IDLE;
      wait_reg   <= 2'h0;
      pd_cnt_reg <= '0;
      cmd_reg    <= CMD_NOP;
      bank_reg   <= 2'h0;
      addr_reg   <= 13'h0000;
      cke_reg    <= 1'b1;
      pend_reg   <= '0;
    end else begin
      cmd_reg <= CMD_NOP;
      case (st_reg)
        SDB_IDLE: begin
          if (cmd_wr) begin
            bank_reg <= reg_wdata[5:4];
            addr_reg <= reg_wdata[28:16];
            case (op)
              SDB_OP_ACT: begin
                cmd_reg  <= CMD_ACT;
                wait_reg <= 2'(RCD_CYC);
                st_reg   <= SDB_WAIT;
              end
              SDB_OP_READ:  cmd_reg <= CMD_READ;
              SDB_OP_WRITE: begin
                if (rd_track_reg != 3'h0) begin
                  pend_reg <= reg_wdata;
                  wait_reg <= 2'(RD_MASK_LAT);
                  st_reg   <= SDB_MASK;
                end else begin
                  cmd_reg <= CMD_WRITE;
                end
              end
              SDB_OP_PRE: begin
                cmd_reg  <= CMD_PRE;
                wait_reg <= 2'(RP_CYC);
                st_reg   <= SDB_WAIT;
              end
              SDB_OP_BSTOP: cmd_reg <= CMD_BSTOP;
              SDB_OP_MODE:  cmd_reg <= CMD_MODE;
              SDB_OP_SLEEP: begin
                cke_reg    <= 1'b0;
                pd_cnt_reg <= '0;
                st_reg     <= SDB_SLEEP;
              end
              default: ;
            endcase
          end
        end
        SDB_WAIT: begin
          wait_reg <= 2'(wait_reg - 1'b1);
          if (wait_reg <= 2'h1) begin
            st_reg <= SDB_IDLE;
          end
        end
        SDB_MASK: begin
          // reads still leaving the device are floated before the write
          wait_reg <= 2'(wait_reg - 1'b1);
          if (wait_reg <= 2'h1) begin
            cmd_reg  <= CMD_WRITE;
            bank_reg <= pend_reg[5:4];
            addr_reg <= pend_reg[28:16];
            st_reg   <= SDB_IDLE;
          end
        end
        SDB_SLEEP: begin
          pd_cnt_reg <= pd_cnt_reg + 32'h1;
          // software wake, or forced wake before refresh is overdue
          if ((reg_wr && reg_addr == REG_CMD && op == SDB_OP_WAKE) ||
              pd_cnt_reg >= 32'(PD_LIMIT - 2)) begin
            cke_reg  <= 1'b1;
            wait_reg <= 2'h1;
            st_reg   <= SDB_WAIT;
          end
        end
        default: st_reg <= SDB_IDLE;
      endcase
    end
  end

  // write data and mask; idle write-burst cycles are masked off
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wd_reg      <= '0;
      wd_oe_n_reg <= 1'b1;
      dqm_reg     <= 1'b0;
      wr_mode_reg <= 1'b0;
    end else begin
      if (cmd_wr && op == SDB_OP_WRITE && rd_track_reg == 3'h0) begin
        wr_mode_reg <= 1'b1;
      end else if (cmd_wr) begin
        wr_mode_reg <= 1'b0;
      end else if (st_reg == SDB_MASK && wait_reg <= 2'h1) begin
        wr_mode_reg <= 1'b1;
      end
      wd_oe_n_reg <= !(data_wr || (cmd_wr && op == SDB_OP_WRITE));
      if (data_wr) begin
        wd_reg <= reg_wdata[DATA_W-1:0];
      end
      // mask for unsent write words and for reads being cut off; a new
      // order drops the idle write mask so a read is not floated, while a
      // write order keeps the mask that came with its first word
      dqm_reg <= (st_reg == SDB_MASK && wait_reg > 2'h1) ||
                 (data_wr ? reg_wdata[16] :
                  cmd_wr  ? (op == SDB_OP_WRITE && dqm_reg) : wr_mode_reg);
    end
  end

  // tracks read words still due so a write waits in SDB_MASK while they are masked
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_track_reg <= 3'h0;
    end else if (cmd_reg == CMD_READ) begin
      rd_track_reg <= 3'h7;
    end else if (cmd_reg == CMD_BSTOP || cmd_reg == CMD_PRE) begin
      rd_track_reg <= 3'(READ_LAT);
    end else if (rd_track_reg != 3'h0 && pins.dq_dev_oe_n) begin
      rd_track_reg <= 3'(rd_track_reg - 1'b1);
    end
  end

  // read capture; the valid bit is sticky until REG_RDATA is read
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_reg  <= '0;
      rvalid_reg <= 1'b0;
    end else if (!pins.dq_dev_oe_n) begin
      rdata_reg  <= pins.dq_dev;
      rvalid_reg <= 1'b1;                                        // set wins
    end else if (reg_rd && reg_addr == REG_RDATA) begin
      rvalid_reg <= 1'b0;
    end
  end

  // register read port, data one cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_RDATA:  reg_rdata <= {15'h0, rvalid_reg, 16'(rdata_reg)};
        REG_STATUS: reg_rdata <= {30'h0, !cke_reg, st_reg != SDB_IDLE};
        REG_WDATA:  reg_rdata <= 32'(wd_reg);
        default:    reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  assign pins.cke              = cke_reg;
  assign {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = cmd_reg;
  assign pins.bank_select_bit0 = bank_reg[0];
  assign pins.bank_select_bit1 = bank_reg[1];
  assign pins.addr             = addr_reg;
  assign pins.dqm              = dqm_reg;
  assign pins.dq_ctl           = wd_reg;
  assign pins.dq_ctl_oe_n      = wd_oe_n_reg;
endmodule

// ==== rtl/sdb_pkg.sv ====
// Purpose: shared constants for the burst memory device and its controller
// Assumes: one clock, command fields sampled on its rising edge
// Notes:   command code is {cs_n, ras_n, cas_n, we_n}
package sdb_pkg;
  // ----------------------------------------------------------------
  // command encodings
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_MODE  = 4'h0;
  localparam logic [3:0] CMD_PRE   = 4'h2;
  localparam logic [3:0] CMD_ACT   = 4'h3;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_READ  = 4'h5;
  localparam logic [3:0] CMD_BSTOP = 4'h6;
  localparam logic [3:0] CMD_NOP   = 4'h7;
  // ----------------------------------------------------------------
  // mode word fields and address bits
  // ----------------------------------------------------------------
  localparam int         MODE_BL_LSB  = 0;    // burst_length_field [2:0]
  localparam int         MODE_BT_BIT  = 3;    // 1 = interleaved order
  localparam int         AP_BIT       = 10;   // auto_precharge_address_bit
  localparam logic [2:0] BL_1         = 3'h0;
  localparam logic [2:0] BL_2         = 3'h1;
  localparam logic [2:0] BL_4         = 3'h2;
  localparam logic [2:0] BL_8         = 3'h3;
  localparam logic [2:0] BL_PAGE      = 3'h7;
  localparam logic [12:0] MODE_RESET  = 13'h0000;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS      = 20;
  localparam int READ_LAT    = 2;             // column read to data
  localparam int RD_MASK_LAT = 2;             // read_mask_latency
  localparam int T_RCD_NS    = 15;
  localparam int T_RP_NS     = 15;
  localparam int RCD_CYC     = (T_RCD_NS + CLK_NS - 1) / CLK_NS;
  localparam int RP_CYC      = (T_RP_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_REF_MS    = 64;
  localparam int REF_CYC     = T_REF_MS * (1000000 / CLK_NS);
  // ----------------------------------------------------------------
  // controller register map
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CMD    = 4'h0;
  localparam logic [3:0] REG_WDATA  = 4'h4;
  localparam logic [3:0] REG_RDATA  = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hc;
  // controller orders, written into REG_CMD bits [3:0]
  typedef enum logic [3:0] {
    SDB_OP_NOP, SDB_OP_ACT, SDB_OP_READ, SDB_OP_WRITE, SDB_OP_PRE,
    SDB_OP_BSTOP, SDB_OP_MODE, SDB_OP_SLEEP, SDB_OP_WAKE
  } sdb_op_t;
endpackage

// ==== rtl/sdb_if.sv ====
// Purpose: pins between the memory controller and the burst memory device
// Assumes: both ends on sys_clk; data bus split into two one-way halves
// Notes:   no bus level is resolved; each end reads the other's drive value directly
`timescale 1ns/10ps
interface sdb_if #(parameter int ADDR_W = 13, parameter int DATA_W = 16);
  logic              cke;
  logic              cs_n;
  logic              ras_n;
  logic              cas_n;
  logic              we_n;
  logic              bank_select_bit0;
  logic              bank_select_bit1;
  logic [ADDR_W-1:0] addr;
  logic              dqm;
  logic [DATA_W-1:0] dq_ctl;      // controller drive value
  logic              dq_ctl_oe_n; // low while controller drives
  logic [DATA_W-1:0] dq_dev;      // device drive value
  logic              dq_dev_oe_n; // low while device drives
  modport ctl (output cke, cs_n, ras_n, cas_n, we_n, bank_select_bit0,
               bank_select_bit1, addr, dqm, dq_ctl, dq_ctl_oe_n,
               input dq_dev, dq_dev_oe_n);
  modport dev (input cke, cs_n, ras_n, cas_n, we_n, bank_select_bit0,
               bank_select_bit1, addr, dqm, dq_ctl, dq_ctl_oe_n,
               output dq_dev, dq_dev_oe_n);
endinterface

// ==== rtl/sdb_dev.sv ====
// What this block does
// - new column command cuts current burst short
// - precharge of burst bank stops burst, closes bank
// - burst stop ends burst, row stays open
// - burst stop drops remaining write data
// - activate opens addressed row in bank
// - column command after row delay; we_n picks direction
// - burst transfers programmed length in aligned block
// - following columns generated internally, seq or interleaved
// - full page only sequential, runs until ended
// - new burst every clock, full new length
// - controller masks reads before write interrupt
// - open banks interleave bursts and precharges
// - read mask floats outputs two clocks later
// - write mask blocks same-clock word
// - controller enters power-down from idle without a precharge
// - low clock enable ignores all other inputs
// - controller wakes before refresh period ends
// - one clock for power-down entry and exit
// - precharge encoding, all-banks bit, bank bits
// - burst length field encodings
// - burst wraps within its aligned block
//
// Purpose: cycle model of a four-bank burst memory device
// Assumes: commands from logic on sys_clk, no synchroniser needed
// Notes:   storage is a small array; rows and columns are parameters
`timescale 1ns/10ps
module sdb_dev #(
  parameter int ROW_W  = 2,
  parameter int COL_W  = 8,
  parameter int DATA_W = 16
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // memory pins
  sdb_if.dev              pins,
  // user-side status
  output logic            powered_down,
  output logic [3:0]      open_banks,
  output logic            burst_busy
);
  import sdb_pkg::*;

  localparam int DEPTH = 4 << (ROW_W + COL_W);

  initial begin
    if (COL_W < 3 || COL_W > 12 || ROW_W < 1 || ROW_W > 13 || DATA_W < 1)
      $error("sdb_dev: unsupported geometry");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // wrap mask of the aligned column block for a burst length code
  function automatic logic [COL_W-1:0] blk_mask(input logic [2:0] bl);
    case (bl)
      BL_2:    blk_mask = COL_W'(1);
      BL_4:    blk_mask = COL_W'(3);
      BL_8:    blk_mask = COL_W'(7);
      BL_PAGE: blk_mask = '1;
      default: blk_mask = '0;                      // reserved codes act as one word
    endcase
  endfunction

  // column of the n-th word of a burst
  function automatic logic [COL_W-1:0] col_at(input logic [COL_W-1:0] start,
                                              input logic [COL_W-1:0] n,
                                              input logic [2:0]       bl,
                                              input logic             il);
    logic [COL_W-1:0] m;
    logic [COL_W-1:0] off;
    m   = blk_mask(bl);
    off = (il && bl != BL_PAGE) ? (start ^ n) : COL_W'(start + n);
    col_at = (start & ~m) | (off & m);
  endfunction

  function automatic int unsigned loc(input logic [1:0]       b,
                                      input logic [ROW_W-1:0] r,
                                      input logic [COL_W-1:0] c);
    loc = 32'({b, r, c});
  endfunction

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  logic             live;
  logic [3:0]       cmd;
  logic [1:0]       bank;
  logic             is_act, is_rd, is_wr, is_pre, is_bst, is_mode;
  logic             pre_hits;

  // inputs count only when clock enable was high one clock before
  assign live     = ~powered_down;
  assign cmd      = {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};
  assign bank     = {pins.bank_select_bit1, pins.bank_select_bit0};
  assign is_act   = live && cmd == CMD_ACT;
  assign is_rd    = live && cmd == CMD_READ && open_banks[bank];
  assign is_wr    = live && cmd == CMD_WRITE && open_banks[bank];
  assign is_pre   = live && cmd == CMD_PRE;
  assign is_bst   = live && cmd == CMD_BSTOP;
  assign is_mode  = live && cmd == CMD_MODE;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] mem [DEPTH];
  logic [ROW_W-1:0]  row_reg [4];
  logic [12:0]       mode_reg;
  logic              b_act_reg;
  logic              b_wr_reg;
  logic [1:0]        b_bank_reg;
  logic [COL_W-1:0]  b_start_reg;
  logic [COL_W-1:0]  b_cnt_reg;
  logic [COL_W-1:0]  b_col;
  logic              b_last;
  logic              s0_v_reg;
  logic              s0_mask_reg;
  logic [DATA_W-1:0] s0_d_reg;
  logic [DATA_W-1:0] dq_out_reg;
  logic              dq_oe_n_reg;

  // precharge hits the burst if all banks or the burst's bank is named
  assign pre_hits = pins.addr[AP_BIT] || bank == b_bank_reg;
  assign b_col  = col_at(b_start_reg, b_cnt_reg, mode_reg[2:0], mode_reg[MODE_BT_BIT]);
  // full page never reaches its end on its own
  assign b_last = mode_reg[2:0] != BL_PAGE &&
                  b_cnt_reg == blk_mask(mode_reg[2:0]);

  // clock enable pipeline: entry and exit both take one clock
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      powered_down <= 1'b0;
    end else begin
      powered_down <= ~pins.cke;
    end
  end

  // mode word; only the burst length and order fields are used here
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_reg <= MODE_RESET;
    end else if (is_mode) begin
      mode_reg <= pins.addr[12:0];
    end
  end

  // bank open flags and latched rows; banks are independent
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      open_banks <= 4'h0;
    end else if (is_act) begin
      open_banks[bank] <= 1'b1;
      row_reg[bank]    <= pins.addr[ROW_W-1:0];
    end else if (is_pre) begin
      if (pins.addr[AP_BIT]) begin
        open_banks <= 4'h0;
      end else begin
        open_banks[bank] <= 1'b0;
      end
    end
  end

  // burst sequencer; a new column command always reloads the count with one
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      b_act_reg   <= 1'b0;
      b_wr_reg    <= 1'b0;
      b_bank_reg  <= 2'h0;
      b_start_reg <= '0;
      b_cnt_reg   <= '0;
    end else if (is_rd || is_wr) begin
      b_act_reg   <= 1'b1;
      b_wr_reg    <= is_wr;
      b_bank_reg  <= bank;
      b_start_reg <= pins.addr[COL_W-1:0];
      b_cnt_reg   <= COL_W'(1);
      if (mode_reg[2:0] == BL_1 || blk_mask(mode_reg[2:0]) == '0) begin
        b_act_reg <= 1'b0;
      end
    end else if (is_bst || (is_pre && pre_hits)) begin
      b_act_reg <= 1'b0;
    end else if (b_act_reg && live) begin
      b_cnt_reg <= COL_W'(b_cnt_reg + 1'b1);
      if (b_last) begin
        b_act_reg <= 1'b0;
      end
    end
  end

  // array writes; mask applies to the word on the same clock
  always_ff @(posedge sys_clk) begin
    if (is_wr && !pins.dqm) begin
      mem[loc(bank, row_reg[bank], pins.addr[COL_W-1:0])] <= pins.dq_ctl;
    end else if (!(is_rd || is_wr || is_bst || (is_pre && pre_hits)) && live &&
                 b_act_reg && b_wr_reg && !pins.dqm) begin
      mem[loc(b_bank_reg, row_reg[b_bank_reg], b_col)] <= pins.dq_ctl;
    end
  end

  // read fetch stage; mask sampled now hides the word two clocks on
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s0_v_reg    <= 1'b0;
      s0_mask_reg <= 1'b0;
      s0_d_reg    <= '0;
    end else begin
      s0_mask_reg <= pins.dqm;
      if (is_rd) begin
        s0_v_reg <= 1'b1;
        s0_d_reg <= mem[loc(bank, row_reg[bank], pins.addr[COL_W-1:0])];
      end else if (is_wr || is_bst || (is_pre && pre_hits) || !live) begin
        s0_v_reg <= 1'b0;
      end else begin
        s0_v_reg <= b_act_reg && !b_wr_reg;
        s0_d_reg <= mem[loc(b_bank_reg, row_reg[b_bank_reg], b_col)];
      end
    end
  end

  // output stage; high impedance shown as raised enable
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dq_out_reg  <= '0;
      dq_oe_n_reg <= 1'b1;
    end else begin
      dq_out_reg  <= s0_d_reg;
      dq_oe_n_reg <= !(s0_v_reg && !s0_mask_reg);
    end
  end

  assign pins.dq_dev      = dq_out_reg;
  assign pins.dq_dev_oe_n = dq_oe_n_reg;

  // busy flag for the user side
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      burst_busy <= 1'b0;
    end else begin
      burst_busy <= (is_rd || is_wr) ? 1'b1 : 1'b0;
      if (!(is_rd || is_wr)) begin
        burst_busy <= b_act_reg && !(is_bst || (is_pre && pre_hits)) &&
                      !(live && b_last);
      end
    end
  end
endmodule

// ==== sim/sdb_assertions.sv ====
// Purpose: pin checks between controller and device
// Assumes: one clock, rst synchronous active high
// Notes:   open banks are not tracked, so bank-dependent cases are left to the bench
`timescale 1ns/10ps
module sdb_assertions (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // pins
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic dqm,
  input wire logic dq_ctl_oe_n,
  input wire logic dq_dev_oe_n
);
  import sdb_pkg::*;
  // -----------------------------------------------------------
  // sequences and checks
  // -----------------------------------------------------------
  wire logic [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // read with output unmasked while the clock keeps running
  sequence rd_go_s;
    cmd == CMD_READ && cke && !dqm ##1 cke;
  endsequence
  // stop or precharge, then a quiet cycle so no new read follows
  sequence stop_s;
    (cmd == CMD_BSTOP || cmd == CMD_PRE) ##1 cmd == CMD_NOP;
  endsequence
  bus_excl_a: assert property (dq_ctl_oe_n || dq_dev_oe_n)
    else $error("both ends drive dq");
  read_lat_a: assert property (rd_go_s |-> ##1 !dq_dev_oe_n)
    else $error("read data late");
  mask_float_a: assert property (dqm |-> ##2 dq_dev_oe_n)
    else $error("masked read word driven");
  burst_stop_a: assert property (stop_s |-> ##1 dq_dev_oe_n)
    else $error("burst kept running");
  wr_drive_a: assert property (cmd == CMD_WRITE |-> !dq_ctl_oe_n)
    else $error("write without data");
  cmd_single_a: assert property (!cs_n && cmd != CMD_NOP |=> cmd == CMD_NOP)
    else $error("command held");
  pd_float_a: assert property (!cke ##1 !cke |-> dq_dev_oe_n)
    else $error("output while powered down");
  data_cause_a: assert property ($fell(dq_dev_oe_n) |-> $past(cmd, 2) == CMD_READ)
    else $error("data without read");
endmodule

// ==== sim/tb.sv ====
// Purpose: drives controller registers and watches the device pins
// Assumes: controller and device joined by one interface
// Notes:   burst words are taken straight off the device data pins
`timescale 1ns/10ps
module tb;
  import sdb_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        powered_down;
  logic [3:0]  open_banks;
  logic        burst_busy;
  logic [31:0] s;
  logic [15:0] q[$];
  int          error_cnt = 0;
  int          check_count = 0;
  int          cyc = 0;
  sdb_if sdb_if_i ();
  sdb_ctl #(.PD_LIMIT(50)) sdb_ctl_i (.sys_clk(sys_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pins(sdb_if_i.ctl));
  sdb_dev sdb_dev_i (.sys_clk(sys_clk), .rst(rst), .pins(sdb_if_i.dev),
    .powered_down(powered_down), .open_banks(open_banks), .burst_busy(burst_busy));
  sdb_assertions sdb_assertions_i (.sys_clk(sys_clk), .rst(rst), .cke(sdb_if_i.cke),
    .cs_n(sdb_if_i.cs_n), .ras_n(sdb_if_i.ras_n), .cas_n(sdb_if_i.cas_n), .we_n(sdb_if_i.we_n),
    .dqm(sdb_if_i.dqm), .dq_ctl_oe_n(sdb_if_i.dq_ctl_oe_n), .dq_dev_oe_n(sdb_if_i.dq_dev_oe_n));
  // clock; the cycle ceiling cuts a hang short, and driven words are collected
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
    if (sdb_if_i.dq_dev_oe_n === 1'b0) q.push_back(sdb_if_i.dq_dev);
  end
  task summarize;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // hold keeps the strobe up so writes can follow with no gap
  task reg_write(input logic [3:0] a, input logic [31:0] d, input bit hold);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    if (!hold) reg_wr <= 1'b0;
  endtask
  task reg_read(input logic [3:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge sys_clk);
  endtask
  task wait_idle;
    for (int i = 0; i < 40; i++) begin
      reg_read(REG_STATUS, s);
      if (s[0] === 1'b0) break;
    end
  endtask
  task cmd(input sdb_op_t op, input logic [12:0] a, input logic [1:0] b = 2'h0);
    wait_idle();
    reg_write(REG_CMD, {3'h0, a, 10'h0, b, op}, 1'b0);
  endtask
  // four words into columns 4..7, word m masked
  task wr_burst(input logic [15:0] base, input int m);
    wait_idle();
    for (int i = 0; i < 4; i++) begin
      reg_write(REG_WDATA, {15'h0, i == m, base + 16'(i)}, i < 3);
      if (i == 0) reg_write(REG_CMD, {16'h0004, 12'h0, SDB_OP_WRITE}, 1'b1);
    end
  endtask
  task rd_burst(input logic [12:0] a, input int n);
    q.delete();
    cmd(SDB_OP_READ, a);
    repeat (n) @(posedge sys_clk);
  endtask
  task t_burst;
    logic [15:0] sq[4] = '{16'h2002, 16'h2003, 16'h2000, 16'h1001};
    logic [15:0] iq[4] = '{16'h1001, 16'h2000, 16'h2003, 16'h2002};
    cmd(SDB_OP_MODE, 13'h0002);
    cmd(SDB_OP_ACT, 13'h0001);
    wait_idle();
    chk(32'(open_banks), 32'h1);
    wr_burst(16'h1000, 9);
    wr_burst(16'h2000, 1);
    rd_burst(13'h0006, 10);
    chk(32'(q.size()), 32'h4);
    for (int i = 0; i < 4; i++) chk(32'(q[i]), 32'(sq[i]));
    cmd(SDB_OP_MODE, 13'h000a);
    rd_burst(13'h0005, 10);
    for (int i = 0; i < 4; i++) chk(32'(q[i]), 32'(iq[i]));
    $display("burst test done");
  endtask
  task t_stop;
    cmd(SDB_OP_MODE, 13'h0003);
    rd_burst(13'h0000, 0);
    cmd(SDB_OP_BSTOP, 13'h0000);
    repeat (12) @(posedge sys_clk);
    chk(32'(q.size() < 8), 32'h1);
    rd_burst(13'h0000, 14);
    chk(32'(q.size()), 32'h8);
    cmd(SDB_OP_MODE, 13'h0007);
    rd_burst(13'h0000, 300);
    chk(32'(q[260]), 32'h2000);
    chk(32'(burst_busy), 32'h1);
    cmd(SDB_OP_BSTOP, 13'h0000);
    repeat (4) @(posedge sys_clk);
    chk(32'(burst_busy), 32'h0);
    q.delete();
    repeat (6) @(posedge sys_clk);
    chk(32'(q.size()), 32'h0);
    $display("stop test done");
  endtask
  task t_pre;
    cmd(SDB_OP_MODE, 13'h0003);
    rd_burst(13'h0000, 0);
    cmd(SDB_OP_PRE, 13'h0000);
    repeat (12) @(posedge sys_clk);
    chk(32'(q.size() < 8), 32'h1);
    chk(32'(open_banks), 32'h0);
    cmd(SDB_OP_ACT, 13'h0001);
    cmd(SDB_OP_ACT, 13'h0002, 2'h2);
    wait_idle();
    chk(32'(open_banks), 32'h5);
    cmd(SDB_OP_PRE, 13'h0400);
    wait_idle();
    chk(32'(open_banks), 32'h0);
    $display("precharge test done");
  endtask
  task t_pd;
    for (int k = 0; k < 2; k++) begin
      cmd(SDB_OP_SLEEP, 13'h0000);
      repeat (3) @(posedge sys_clk);
      chk(32'(powered_down), 32'h1);
      if (k == 0) reg_write(REG_CMD, {28'h0, SDB_OP_WAKE}, 1'b0);
      else repeat (60) @(posedge sys_clk);
      repeat (3) @(posedge sys_clk);
      chk(32'(powered_down), 32'h0);
    end
    reg_read(4'h2, s);
    chk(s, 32'h0);
    $display("power-down test done");
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_burst();
    t_stop();
    t_pre();
    t_pd();
    summarize();
  end
endmodule
